// *** core/tcc_cap_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcc_cap_sync import tcc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Event sources
  input wire logic capture_event_pin,
  input wire logic alt_source,
  input wire logic use_alt,
  // Qualified event
  output logic capture_event
);

  tcc_sync_s st;
  tcc_sync_s next_st;
  logic sel;

  // Only stage two is read; a source switch may look like one edge
  always_comb begin
    next_st = st;
    next_st.pin_s1 = {alt_source, capture_event_pin};
    next_st.pin_s2 = st.pin_s1;
    sel = use_alt ? st.pin_s2[1] : st.pin_s2[0];
    next_st.prev = sel;
    next_st.evt = sel & ~st.prev; // [RL5]
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign capture_event = st.evt;

endmodule // tcc_cap_sync
`default_nettype wire

// *** core/tcc_cmp_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcc_cmp_unit import tcc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Counter side
  input wire logic [15:0] count_value,
  input wire logic count_tick,
  input wire logic [15:0] compare_value,
  // Match pulse
  output logic match
);

  tcc_cmp_s st;
  tcc_cmp_s next_st;

  always_comb begin
    next_st.match = count_tick & (count_value == compare_value); // [RL1]
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign match = st.match;

endmodule // tcc_cmp_unit
`default_nettype wire

// *** core/tcc_timer_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_timer_regs import tcc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter core, timers 1, 3, 4, 5 at index 0..3
  input wire logic [3:0][15:0] count_value,
  input wire logic [3:0] count_tick,
  input wire logic [3:0] overflow_event,
  // Capture sources
  input wire logic [3:0] capture_event_pin,
  input wire logic comparator_out,
  // CPU global interrupt enable
  input wire logic global_irq_enable,
  // Waveform and top-limit outputs
  output logic [3:0][2:0] compare_wave_pin,
  output logic [3:0][15:0] capture_top,
  // Interrupts
  output tcc_req_s [3:0] irq_vector_req,
  output logic irq
);

  // ----------------------------------------
  // Address map tables
  // ----------------------------------------
  localparam logic [3:0][9:0] BASE_IDX = {`TCC_T5_BASE, `TCC_T4_BASE, `TCC_T3_BASE,
                                          `TCC_T1_BASE};
  localparam logic [3:0][9:0] MASK_IDX = {`TCC_T5_MASK, `TCC_T4_MASK, `TCC_T3_MASK,
                                          `TCC_T1_MASK};

  tcc_main_s st;
  tcc_main_s next_st;
  logic [3:0][2:0] cmp_match;
  logic [3:0] cap_evt;
  logic [9:0] idx;
  logic setup_phase;
  logic access_wr;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [7:0] rd_temp;
  logic rd_temp_load;
  logic wr_hit;
  logic [3:0][7:0] ev;
  logic [3:0][7:0] pend;

  assign idx = paddr[11:2];
  assign setup_phase = psel & ~penable;
  assign access_wr = psel & penable & pwrite;

  // ----------------------------------------
  // Compare units and capture synchronisers
  // ----------------------------------------
  genvar gt;
  genvar gc;
  generate
    for (gt = 0; gt < 4; gt++) begin : g_tmr
      for (gc = 0; gc < 3; gc++) begin : g_ch
        tcc_cmp_unit u_cmp (
          .sys_clk(sys_clk),
          .rstn(rstn),
          .count_value(count_value[gt]),
          .count_tick(count_tick[gt]),
          .compare_value(st.cmp[gt][gc]),
          .match(cmp_match[gt][gc])
        );
      end
      // Only timer 1 may take the comparator as its source
      tcc_cap_sync u_cap (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .capture_event_pin(capture_event_pin[gt]),
        .alt_source((gt == 0) ? comparator_out : 1'b0),
        .use_alt((gt == 0) ? st.cfg[gt][`TCC_CFG_BIT_ACO] : 1'b0),
        .capture_event(cap_evt[gt])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read decode, taken in the setup cycle
  // ----------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b0;
    rd_temp = st.temp;
    rd_temp_load = 1'b0;
    for (int t = 0; t < 4; t++) begin
      if (idx == BASE_IDX[t] + `TCC_OFS_CAP_LO) begin
        rd_byte = st.cap[t][7:0];
        rd_temp = st.cap[t][15:8]; // [RL7]
        rd_temp_load = 1'b1;
        rd_hit = 1'b1;
      end else if (idx == BASE_IDX[t] + `TCC_OFS_CAP_HI) begin
        rd_byte = st.temp; // [RL7]
        rd_hit = 1'b1;
      end else if (idx == MASK_IDX[t]) begin
        rd_byte = st.mask[t] & `TCC_EVT_WMASK; // [RL13]
        rd_hit = 1'b1;
      end else if (idx == `TCC_FLAG_BASE + 10'(t)) begin
        rd_byte = st.flag[t];
        rd_hit = 1'b1;
      end else if (idx == `TCC_CFG_BASE + 10'(t)) begin
        rd_byte = st.cfg[t];
        rd_hit = 1'b1;
      end else begin
        for (int c = 0; c < 3; c++) begin
          if (idx == BASE_IDX[t] + `TCC_OFS_CMP_LO + 10'(2 * c)) begin
            rd_byte = st.cmp[t][c][7:0];
            rd_hit = 1'b1;
          end else if (idx == BASE_IDX[t] + `TCC_OFS_CMP_LO + 10'(2 * c + 1)) begin
            // Compare values read back directly, no latch involved
            rd_byte = st.cmp[t][c][15:8];
            rd_hit = 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Write decode hit
  // ----------------------------------------
  always_comb begin
    wr_hit = 1'b0;
    for (int t = 0; t < 4; t++) begin
      if (idx == BASE_IDX[t] + `TCC_OFS_CAP_LO || idx == BASE_IDX[t] + `TCC_OFS_CAP_HI) begin
        wr_hit = 1'b1;
      end else if (idx == MASK_IDX[t] || idx == `TCC_FLAG_BASE + 10'(t)) begin
        wr_hit = 1'b1;
      end else if (idx == `TCC_CFG_BASE + 10'(t)) begin
        wr_hit = 1'b1;
      end else if (idx >= BASE_IDX[t] + `TCC_OFS_CMP_LO &&
                   idx < BASE_IDX[t] + `TCC_OFS_CMP_LO + 10'h006) begin
        wr_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Event vector per timer, flag layout
  // ----------------------------------------
  always_comb begin
    for (int t = 0; t < 4; t++) begin
      ev[t] = 8'h00;
      ev[t][`TCC_BIT_CAP] = cap_evt[t];
      ev[t][`TCC_BIT_CMP_C] = cmp_match[t][2]; // [RL2]
      ev[t][`TCC_BIT_CMP_B] = cmp_match[t][1]; // [RL2]
      ev[t][`TCC_BIT_CMP_A] = cmp_match[t][0]; // [RL2]
      ev[t][`TCC_BIT_OVF] = overflow_event[t];
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;

    // Read data and the latch load happen together so both bytes agree
    if (setup_phase) begin
      next_st.prdata = {24'h000000, rd_byte};
      next_st.pslverr = pwrite ? ~wr_hit : ~rd_hit;
      if (!pwrite && rd_temp_load) begin
        next_st.temp = rd_temp; // [RL4]
      end
    end

    if (access_wr) begin
      for (int t = 0; t < 4; t++) begin
        if (idx == BASE_IDX[t] + `TCC_OFS_CAP_HI) begin
          next_st.temp = pwdata[7:0]; // [RL3] [RL4]
        end else if (idx == BASE_IDX[t] + `TCC_OFS_CAP_LO) begin
          next_st.cap[t] = {st.temp, pwdata[7:0]};
        end else if (idx == MASK_IDX[t]) begin
          next_st.mask[t] = pwdata[7:0] & `TCC_EVT_WMASK; // [RL13]
        end else if (idx == `TCC_FLAG_BASE + 10'(t)) begin
          next_st.flag[t] = st.flag[t] & ~(pwdata[7:0] & `TCC_EVT_WMASK);
        end else if (idx == `TCC_CFG_BASE + 10'(t)) begin
          next_st.cfg[t] = pwdata[7:0];
        end else begin
          for (int c = 0; c < 3; c++) begin
            if (idx == BASE_IDX[t] + `TCC_OFS_CMP_LO + 10'(2 * c + 1)) begin
              next_st.temp = pwdata[7:0]; // [RL3] [RL4]
            end else if (idx == BASE_IDX[t] + `TCC_OFS_CMP_LO + 10'(2 * c)) begin
              next_st.cmp[t][c] = {st.temp, pwdata[7:0]}; // [RL3]
            end
          end
        end
      end
    end

    // Hardware events win over a same-cycle clear or write
    for (int t = 0; t < 4; t++) begin
      if (cap_evt[t]) begin
        next_st.cap[t] = count_value[t]; // [RL5]
      end
      next_st.flag[t] = next_st.flag[t] | ev[t];
      for (int c = 0; c < 3; c++) begin
        if (cmp_match[t][c] && st.cfg[t][`TCC_CFG_BIT_WAVE + c]) begin
          next_st.wave[t][c] = ~st.wave[t][c]; // [RL2]
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= '0;
      for (int t = 0; t < 4; t++) begin
        st.mask[t] <= `TCC_MASK_RST; // [RL13]
        st.flag[t] <= `TCC_FLAG_RST;
        st.cfg[t] <= `TCC_CFG_RST;
      end
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  always_comb begin
    for (int t = 0; t < 4; t++) begin
      pend[t] = st.flag[t] & st.mask[t];
      irq_vector_req[t].capture = global_irq_enable & pend[t][`TCC_BIT_CAP]; // [RL8]
      irq_vector_req[t].compare_c = global_irq_enable & pend[t][`TCC_BIT_CMP_C]; // [RL9]
      irq_vector_req[t].compare_b = global_irq_enable & pend[t][`TCC_BIT_CMP_B]; // [RL10]
      irq_vector_req[t].compare_a = global_irq_enable & pend[t][`TCC_BIT_CMP_A]; // [RL11]
      irq_vector_req[t].overflow = global_irq_enable & pend[t][`TCC_BIT_OVF]; // [RL12]
    end
  end

  assign irq = global_irq_enable & (|pend);

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign pready = 1'b1;
  assign compare_wave_pin = st.wave;
  assign capture_top = st.cap; // [RL6]

endmodule // tcc_timer_regs
`default_nettype wire

// *** include/tcc_defines.svh ***
// Functional notes
// RL1: Compare each value with count every tick.
// RL2: Match raises compare flag, may toggle pin.
// RL3: Write high byte to latch, low commits.
// RL4: One high-byte latch shared by every register.
// RL5: Capture count on pin event, comparator option.
// RL6: Capture value offered as counter top limit.
// RL7: Low-byte read latches high byte for later.
// RL8: Capture request needs mask bit 5, global.
// RL9: Compare-C request needs mask bit 3, global.
// RL10: Compare-B request needs mask bit 2, global.
// RL11: Compare-A request needs mask bit 1, global.
// RL12: Overflow request needs mask bit 0, global.
// RL13: Mask bits 7,6,4 read zero; reset zero.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define TCC_T1_BASE 10'h080
`define TCC_T3_BASE 10'h090
`define TCC_T4_BASE 10'h0a0
`define TCC_T5_BASE 10'h120
`define TCC_OFS_CAP_LO 10'h006
`define TCC_OFS_CAP_HI 10'h007
`define TCC_OFS_CMP_LO 10'h008
`define TCC_T1_MASK 10'h06f
`define TCC_T3_MASK 10'h071
`define TCC_T4_MASK 10'h072
`define TCC_T5_MASK 10'h073
`define TCC_FLAG_BASE 10'h040
`define TCC_CFG_BASE 10'h048

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TCC_BIT_OVF 0
`define TCC_BIT_CMP_A 1
`define TCC_BIT_CMP_B 2
`define TCC_BIT_CMP_C 3
`define TCC_BIT_CAP 5
`define TCC_CFG_BIT_ACO 0
`define TCC_CFG_BIT_WAVE 1
`define TCC_EVT_WMASK 8'h2f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCC_MASK_RST 8'h00
`define TCC_FLAG_RST 8'h00
`define TCC_CFG_RST 8'h00

`endif

// *** include/tcc_pkg.sv ***
package tcc_pkg;

  // Capture synchroniser state
  typedef struct packed {
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic prev;
    logic evt;
  } tcc_sync_s;

  // Compare unit state
  typedef struct packed {
    logic match;
  } tcc_cmp_s;

  // Per-timer interrupt requests
  typedef struct packed {
    logic capture;
    logic compare_c;
    logic compare_b;
    logic compare_a;
    logic overflow;
  } tcc_req_s;

  // Main block state
  typedef struct packed {
    logic [3:0][2:0][15:0] cmp;
    logic [3:0][15:0] cap;
    logic [3:0][7:0] mask;
    logic [3:0][7:0] flag;
    logic [3:0][7:0] cfg;
    logic [3:0][2:0] wave;
    logic [7:0] temp;
    logic [31:0] prdata;
    logic pslverr;
  } tcc_main_s;

endpackage

// *** tb/tcc_count_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcc_count_model import tcc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bench control
  input wire logic [3:0] load,
  input wire logic [15:0] load_val,
  input wire logic [3:0] step,
  // Counter side
  output logic [3:0][15:0] count_value,
  output logic [3:0] count_tick,
  output logic [3:0] overflow_event
);
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rstn) begin
        count_value[i] <= 16'h0;
      end else if (load[i]) begin
        count_value[i] <= load_val;
      end else if (step[i]) begin
        count_value[i] <= count_value[i] + 16'h1;
      end
      count_tick[i] <= rstn && step[i];
      overflow_event[i] <= rstn && step[i] && count_value[i] == 16'hffff;
    end
  end
endmodule // tcc_count_model
`default_nettype wire

// *** tb/tcc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcc_props import tcc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and results
  input wire logic [3:0] count_tick,
  input wire logic [3:0] capture_event_pin,
  input wire logic comparator_out,
  input wire logic global_irq_enable,
  input wire logic [3:0][2:0] compare_wave_pin,
  input wire logic [3:0][15:0] capture_top,
  input wire tcc_req_s [3:0] irq_vector_req,
  input wire logic irq
);
  logic [4:0] src_q;
  logic [3:0] pin_age;
  logic [2:0] tick_age;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Ages saturate so a stale cause never excuses a change
  always_ff @(posedge sys_clk) begin
    src_q <= {comparator_out, capture_event_pin};
    if (!rstn) begin
      pin_age <= 4'hf;
    end else if (|({comparator_out, capture_event_pin} & ~src_q)) begin
      pin_age <= 4'h0;
    end else if (pin_age != 4'hf) begin
      pin_age <= pin_age + 4'h1;
    end
    if (!rstn) begin
      tick_age <= 3'h7;
    end else if (|count_tick) begin
      tick_age <= 3'h0;
    end else if (tick_age != 3'h7) begin
      tick_age <= tick_age + 3'h1;
    end
  end
  sequence s_rd_mask;
    psel && penable && !pwrite && (paddr[11:2] inside {10'h06f, 10'h071, 10'h072, 10'h073});
  endsequence
  sequence s_rd_bad;
    psel && penable && !pwrite && paddr[11:2] == 10'h3ff;
  endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_upper_zero: assert property (psel && penable |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_mask_rsvd: assert property (s_rd_mask |-> prdata[7:6] == 2'h0 && !prdata[4] && !pslverr)
    else $error("mask unused bits set");
  chk_unmapped_err: assert property (s_rd_bad |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_req_global: assert property (!global_irq_enable |-> irq_vector_req == '0)
    else $error("request without global enable");
  chk_irq_any: assert property (irq == (|irq_vector_req))
    else $error("irq differs from requests");
  chk_cap_cause: assert property ($changed(capture_top) |-> pin_age <= 4'h6)
    else $error("capture without event");
  chk_wave_cause: assert property ($changed(compare_wave_pin) |-> tick_age <= 3'h3)
    else $error("wave change without tick");
  chk_reset_quiet: assert property ($rose(rstn) |-> irq == 1'b0 && compare_wave_pin == '0)
    else $error("outputs active after reset");
endmodule // tcc_props
bind tcc_timer_regs tcc_props u_props (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .count_tick, .capture_event_pin, .comparator_out,
  .global_irq_enable, .compare_wave_pin, .capture_top, .irq_vector_req, .irq);
`default_nettype wire

// *** tb/timer16_compare_capture_irq_mask_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer16_compare_capture_irq_mask_test import tcc_pkg::*;;
  logic sys_clk, rstn, psel, penable, pwrite, comparator_out, global_irq_enable;
  logic pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, rd;
  logic [3:0] step, load, capture_event_pin, count_tick, overflow_event;
  logic [15:0] load_val, v, c;
  logic [4:0] exp5;
  logic [3:0][15:0] count_value, capture_top;
  logic [3:0][2:0] compare_wave_pin;
  tcc_req_s [3:0] irq_vector_req;
  int error_cnt, num_checks, mdl_tmp;
  int bits[5] = '{0, 1, 2, 3, 5};
  logic [9:0] mask_ix[4] = '{10'h06f, 10'h071, 10'h072, 10'h073};
  tcc_timer_regs dut_u (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .count_value, .count_tick, .overflow_event, .capture_event_pin,
    .comparator_out, .global_irq_enable, .compare_wave_pin, .capture_top, .irq_vector_req, .irq);
  tcc_count_model cnt_u (.sys_clk, .rstn, .load, .load_val, .step, .count_value, .count_tick,
    .overflow_event);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Model of the one shared high-byte latch
    if (w && ix[0] && ix >= 10'h080) mdl_tmp = d;
  endtask
  task automatic rd_chk(input string n, input logic [9:0] ix, input logic [31:0] e);
    apb(1'b0, ix, 8'h0);
    chk(n, e, rd);
  endtask
  task automatic wr16(input logic [9:0] ix, input logic [15:0] d);
    apb(1'b1, ix + 10'h1, d[15:8]);
    apb(1'b1, ix, d[7:0]);
  endtask
  task automatic tick(input int i, input logic [15:0] val);
    @(posedge sys_clk);
    load <= 4'h1 << i;
    load_val <= val;
    @(posedge sys_clk);
    load <= 4'h0;
    step <= 4'h1 << i;
    @(posedge sys_clk);
    step <= 4'h0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic cap(input int i, input logic [15:0] val, input logic alt);
    @(posedge sys_clk);
    load <= 4'h1 << i;
    load_val <= val;
    @(posedge sys_clk);
    load <= 4'h0;
    capture_event_pin <= alt ? 4'h0 : 4'h1 << i;
    comparator_out <= alt;
    repeat (8) @(posedge sys_clk);
    capture_event_pin <= 4'h0;
    comparator_out <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    {rstn, psel, penable, pwrite, comparator_out, global_irq_enable} = 6'h0;
    {paddr, pwdata, step, load, load_val, capture_event_pin} = '0;
    error_cnt = 0;
    num_checks = 0;
    mdl_tmp = 0;
    rnd = 32'h1a7b;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (mask_ix[t]) begin
      rd_chk("mask reset", mask_ix[t], 32'h0);
      apb(1'b1, mask_ix[t], 8'hff);
      rd_chk("mask bits", mask_ix[t], 32'h2f);
    end
    apb(1'b0, 10'h3ff, 8'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 10'h3ff, 8'hff);
    chk("unmapped wr", 32'h1, {31'h0, err});
    rnd = lfsr(rnd);
    v = rnd[15:0] | 16'h1;
    apb(1'b1, 10'h089, ~v[15:8]);
    apb(1'b1, 10'h09b, v[15:8]);
    apb(1'b1, 10'h088, v[7:0]);
    rd_chk("cmp a hi", 10'h089, mdl_tmp);
    rd_chk("cmp a lo", 10'h088, {24'h0, v[7:0]});
    wr16(10'h08a, v);
    wr16(10'h08c, v);
    apb(1'b1, 10'h048, 8'h0e);
    tick(0, v - 16'h1);
    chk("wave", 32'h7, {29'h0, compare_wave_pin[0]});
    rd_chk("cmp flags", 10'h040, 32'h0e);
    wr16(10'h128, v);
    apb(1'b1, 10'h04b, 8'h02);
    tick(3, v - 16'h1);
    chk("wave t5", 32'h1, {29'h0, compare_wave_pin[3]});
    tick(0, 16'hffff);
    rnd = lfsr(rnd);
    c = rnd[15:0];
    cap(0, c, 1'b0);
    chk("top", {16'h0, c}, {16'h0, capture_top[0]});
    rd_chk("cap lo", 10'h086, {24'h0, c[7:0]});
    mdl_tmp = c[15:8];
    cap(0, ~c, 1'b0);
    rd_chk("cap hi", 10'h087, mdl_tmp);
    rd_chk("flags", 10'h040, 32'h2f);
    foreach (bits[k]) begin
      apb(1'b1, 10'h06f, 8'h1 << bits[k]);
      global_irq_enable <= 1'b1;
      exp5 = bits[k] == 5 ? 5'h10 : 5'h1 << bits[k];
      @(posedge sys_clk);
      chk("req", {27'h0, exp5}, {27'h0, irq_vector_req[0]});
      chk("irq on", 32'h1, {31'h0, irq});
      global_irq_enable <= 1'b0;
      @(posedge sys_clk);
      chk("irq off", 32'h0, {31'h0, irq});
    end
    // Comparator as the capture source of timer 1
    apb(1'b1, 10'h048, 8'h0f);
    rnd = lfsr(rnd);
    cap(0, rnd[15:0], 1'b1);
    chk("top alt", {16'h0, rnd[15:0]}, {16'h0, capture_top[0]});
    apb(1'b1, 10'h040, 8'h2f);
    rd_chk("flags clear", 10'h040, 32'h0);
    // Reset in mid-run with waves and masks still set
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    chk("wave reset", 32'h0, {20'h0, compare_wave_pin});
    chk("top reset", 32'h0, {16'h0, capture_top[0]});
    rd_chk("mask after reset", 10'h071, 32'h0);
    report_and_stop;
  end
endmodule // timer16_compare_capture_irq_mask_test
`default_nettype wire
